// ---- rtl/plsb_pkg.sv ----
// plsb_pkg: constants and types for the port indicator select and boot strap block.
// assumes a 125 MHz system clock and an APB slave with 32-bit data.
package plsb_pkg;

	// ----------------------------------------
	// clock and reset timing
	// ----------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 8;
	localparam int unsigned RESET_MIN_CYCLES = 256;
	localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h2;

	// ----------------------------------------
	// register byte offsets
	// ----------------------------------------
	localparam logic [11:0] WAN_MISC_CTRL_OFS = 12'h000;
	localparam logic [11:0] SWITCH_CTRL0_OFS = 12'h004;
	localparam logic [11:0] STRAP_STATUS_OFS = 12'h008;
	localparam logic [11:0] INDICATOR_STATE_OFS = 12'h00C;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int unsigned WAN_SEL0_LSB = 0;
	localparam int unsigned WAN_SEL1_LSB = 4;
	localparam int unsigned LAN_SEL0_LSB = 25;
	localparam int unsigned LAN_SEL1_LSB = 22;
	localparam int unsigned SEL_WIDTH = 3;
	localparam int unsigned STS_WIDTH_LSB = 0;
	localparam int unsigned STS_CPUCLK_BIT = 2;
	localparam int unsigned STS_RSVD_BIT = 3;
	localparam int unsigned STS_LATCHED_BIT = 4;
	localparam int unsigned LAN_PORTS = 4;

	// ----------------------------------------
	// reset values of the selector fields
	// ----------------------------------------
	localparam logic [2:0] WAN_SEL0_RESET = 3'h1;
	localparam logic [2:0] WAN_SEL1_RESET = 3'h4;
	localparam logic [2:0] LAN_SEL0_RESET = 3'h1;
	localparam logic [2:0] LAN_SEL1_RESET = 3'h4;

	// ----------------------------------------
	// indicator selector codes
	// ----------------------------------------
	localparam logic [2:0] SEL_SPEED = 3'h0;
	localparam logic [2:0] SEL_LINK = 3'h1;
	localparam logic [2:0] SEL_DUPLEX = 3'h2;
	localparam logic [2:0] SEL_COLLISION = 3'h3;
	localparam logic [2:0] SEL_ACTIVITY = 3'h4;
	localparam logic [2:0] SEL_FD_COLLISION = 3'h5;
	localparam logic [2:0] SEL_LINK_ACT = 3'h6;

	// ----------------------------------------
	// boot bank width strap codes
	// ----------------------------------------
	localparam logic [1:0] WIDTH_RESERVED = 2'h0;
	localparam logic [1:0] WIDTH_8BIT = 2'h1;
	localparam logic [1:0] WIDTH_16BIT = 2'h2;
	localparam logic [1:0] WIDTH_32BIT = 2'h3;

	// strap handling sequence, gray coded
	typedef enum logic [1:0] {
		ST_SAMPLE = 2'h0,
		ST_SETTLE = 2'h1,
		ST_RUN = 2'h3
	} plsb_state_e;

	// per port status from the phy and mac
	typedef struct packed {
		logic speed100;
		logic linkUp;
		logic fullDuplex;
		logic collision;
		logic activity;
	} plsb_port_stat_s;

	// decoded strap results
	typedef struct packed {
		logic [1:0] bootBankWidthStrap;
		logic width8;
		logic width16;
		logic width32;
		logic widthReserved;
		logic cpuClockSourceStrap;
	} plsb_strap_s;

endpackage

// ---- rtl/plsb_led_strap.sv ----
// plsb_led_strap: port indicator selection and reset-time strap capture.
// assumes port status from phy/mac logic on clk, apb master on clk,
// and board pull resistors that hold the strap pins during reset.
// one clock domain, no interrupt and no buffering of its own.
//
// What this block does
// - wan indicator 0 shows the event chosen by wan misc control bits [2:0].
// - wan indicator 1 shows the event chosen by wan misc control bits [6:4].
// - lan indicator 0 of all four ports follows switch control 0 bits [27:25].
// - lan indicator 1 of all four ports follows switch control 0 bits [24:22].
// - codes 000 to 011 show speed, link, duplex and collision.
// - codes 100 to 110 show activity, full-duplex collision and link without activity.
// - during reset the wan indicator pins are inputs forming the width strap.
// - strap 01 means 8 bits, 10 means 16 bits, 11 means 32 bits, 00 is reserved.
// - boot fetch from bank 0 uses the strapped width, which the board must hold valid.
// - during reset the request-to-send pin gives the cpu clock source strap.
// - once the straps are latched the request-to-send pin is an active low transmit request.
`timescale 1ns/1ps

module plsb_led_strap
	import plsb_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// port status from phy and mac logic
	input wire plsb_port_stat_s wanStat,
	input wire plsb_port_stat_s [LAN_PORTS-1:0] lanStat,
	// uart transmit request, active high
	input wire logic serialTxRequest,
	// wan indicator 0 pin, shared with strap bit 0
	input wire logic wanIndicator0In,
	output logic wanIndicator0Out,
	output logic wanIndicator0Oe,
	// wan indicator 1 pin, shared with strap bit 1
	input wire logic wanIndicator1In,
	output logic wanIndicator1Out,
	output logic wanIndicator1Oe,
	// request-to-send pin, shared with cpu clock strap
	input wire logic serialRequestToSendIn,
	output logic serialRequestToSendOut_n,
	output logic serialRequestToSendOe,
	// lan indicator pins, index 0 is port 1
	output logic [LAN_PORTS-1:0] lanIndicator0,
	output logic [LAN_PORTS-1:0] lanIndicator1,
	// latched strap results
	output plsb_strap_s strap,
	output logic strapLatched
);

	// ----------------------------------------
	// state
	// ----------------------------------------

	// all registered state of the block
	typedef struct packed {
		plsb_state_e st;
		logic [1:0] settle;
		logic [1:0] widthSync1;
		logic [1:0] widthSync2;
		logic rtsSync1;
		logic rtsSync2;
		logic [1:0] bankWidth;
		logic cpuClkStrap;
		plsb_strap_s strapDec;
		logic [2:0] wanSel0;
		logic [2:0] wanSel1;
		logic [2:0] lanSel0;
		logic [2:0] lanSel1;
		logic wanLed0;
		logic wanLed1;
		logic [LAN_PORTS-1:0] lanLed0;
		logic [LAN_PORTS-1:0] lanLed1;
		logic rtsOut_n;
		logic [31:0] rdata;
		logic slvErr;
	} plsb_regs_s;

	plsb_regs_s state_reg;
	plsb_regs_s state_next;

	// ----------------------------------------
	// helpers
	// ----------------------------------------

	// map a selector code onto one port's status
	// code 111 has no event and keeps the indicator dark
	// one decoder for all ports so wan and lan agree
	function automatic logic showEvent(input logic [2:0] sel, input plsb_port_stat_s s);
		case (sel)
			SEL_SPEED: showEvent = s.speed100;
			SEL_LINK: showEvent = s.linkUp;
			SEL_DUPLEX: showEvent = s.fullDuplex;
			SEL_COLLISION: showEvent = s.collision;
			SEL_ACTIVITY: showEvent = s.activity;
			SEL_FD_COLLISION: showEvent = s.collision & s.fullDuplex;
			SEL_LINK_ACT: showEvent = s.linkUp & ~s.activity;
			default: showEvent = 1'b0;
		endcase
	endfunction

	// expand byte strobes into a bit mask
	// byte lane i covers bits 8i to 8i+7
	function automatic logic [31:0] strobeMask(input logic [3:0] strb);
		logic [31:0] m;
		m = 32'h0000_0000;
		for (int i = 0; i < 4; i++) begin
			m[i*8 +: 8] = {8{strb[i]}};
		end
		strobeMask = m;
	endfunction

	// merge written bits of a field under the byte mask
	// bits whose lane is off keep their old value
	function automatic logic [2:0] mergeField(input logic [2:0] old, input logic [2:0] wr,
		input logic [2:0] msk);
		mergeField = (old & ~msk) | (wr & msk);
	endfunction

	// ----------------------------------------
	// access decode
	// ----------------------------------------

	logic setupPhase;
	logic writeAccess;
	logic [31:0] wrMask;
	logic addrHit;
	logic hitWan;
	logic hitSw;
	logic hitStrap;
	logic hitInd;
	logic [31:0] wanCtrlView;
	logic [31:0] swCtrlView;
	logic [31:0] strapView;
	logic [31:0] indView;

	// setup cycle and write access flags and the byte mask
	assign setupPhase = psel & ~penable;
	assign writeAccess = psel & penable & pwrite;
	assign wrMask = strobeMask(pstrb);

	// one hit per mapped word, any other address earns an error
	assign hitWan = (paddr == WAN_MISC_CTRL_OFS);
	assign hitSw = (paddr == SWITCH_CTRL0_OFS);
	assign hitStrap = (paddr == STRAP_STATUS_OFS);
	assign hitInd = (paddr == INDICATOR_STATE_OFS);
	assign addrHit = hitWan | hitSw | hitStrap | hitInd;

	// read views of each register
	// unused bits read as zero
	always_comb begin
		wanCtrlView = 32'h0000_0000;
		wanCtrlView[WAN_SEL0_LSB +: SEL_WIDTH] = state_reg.wanSel0;
		wanCtrlView[WAN_SEL1_LSB +: SEL_WIDTH] = state_reg.wanSel1;
		swCtrlView = 32'h0000_0000;
		swCtrlView[LAN_SEL0_LSB +: SEL_WIDTH] = state_reg.lanSel0;
		swCtrlView[LAN_SEL1_LSB +: SEL_WIDTH] = state_reg.lanSel1;
		strapView = 32'h0000_0000;
		strapView[STS_WIDTH_LSB +: 2] = state_reg.bankWidth;
		strapView[STS_CPUCLK_BIT] = state_reg.cpuClkStrap;
		strapView[STS_RSVD_BIT] = (state_reg.bankWidth == WIDTH_RESERVED);
		strapView[STS_LATCHED_BIT] = (state_reg.st == ST_RUN);
		indView = {22'h00_0000, state_reg.lanLed1, state_reg.lanLed0,
			state_reg.wanLed1, state_reg.wanLed0};
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------

	// one combinational pass over all state
	always_comb begin
		state_next = state_reg;

		// pin synchronisers, first stage read only by second
		// straps and the rts pin are sampled only through these
		state_next.widthSync1 = {wanIndicator1In, wanIndicator0In};
		state_next.widthSync2 = state_reg.widthSync1;
		state_next.rtsSync1 = serialRequestToSendIn;
		state_next.rtsSync2 = state_reg.rtsSync1;

		// strap sequence after reset release:
		// edge 1 loads the first sync stage, edge 2 the second,
		// edge 3 takes the synchronised pins and hands the pins to the outputs.
		// the board must keep the straps steady over these edges,
		// as the pins stay released until the sequence reaches run.
		case (state_reg.st)
			ST_SAMPLE: begin
				state_next.settle = 2'h0;
				state_next.st = ST_SETTLE;
			end
			ST_SETTLE: begin
				state_next.settle = state_reg.settle + 2'h1;
				if (state_reg.settle == STRAP_SETTLE_CYCLES - 2'h1) begin
					state_next.bankWidth = state_reg.widthSync2;
					state_next.cpuClkStrap = state_reg.rtsSync2;
					// decoded once here so the strap outputs come from flops
					state_next.strapDec.bootBankWidthStrap = state_reg.widthSync2;
					state_next.strapDec.width8 = (state_reg.widthSync2 == WIDTH_8BIT);
					state_next.strapDec.width16 = (state_reg.widthSync2 == WIDTH_16BIT);
					state_next.strapDec.width32 = (state_reg.widthSync2 == WIDTH_32BIT);
					state_next.strapDec.widthReserved = (state_reg.widthSync2 == WIDTH_RESERVED);
					state_next.strapDec.cpuClockSourceStrap = state_reg.rtsSync2;
					state_next.st = ST_RUN;
				end
			end
			ST_RUN: begin
				state_next.settle = state_reg.settle;
			end
			default: begin
				state_next.st = ST_SAMPLE;
			end
		endcase

		// indicator selection for wan port
		// output follows status one edge later
		state_next.wanLed0 = showEvent(state_reg.wanSel0, wanStat);
		state_next.wanLed1 = showEvent(state_reg.wanSel1, wanStat);

		// indicator selection for lan ports, shared selectors
		// one selector pair drives all four ports alike
		for (int p = 0; p < LAN_PORTS; p++) begin
			state_next.lanLed0[p] = showEvent(state_reg.lanSel0, lanStat[p]);
			state_next.lanLed1[p] = showEvent(state_reg.lanSel1, lanStat[p]);
		end

		// transmit request, active low on the pin
		// one flop of delay keeps the pin free of glitches
		state_next.rtsOut_n = ~serialTxRequest;

		// read data and error captured in the setup cycle;
		// the access cycle then answers at once with pready tied high,
		// and prdata stands until the next setup cycle
		if (setupPhase) begin
			state_next.slvErr = ~addrHit;
			case (paddr)
				WAN_MISC_CTRL_OFS: state_next.rdata = wanCtrlView;
				SWITCH_CTRL0_OFS: state_next.rdata = swCtrlView;
				STRAP_STATUS_OFS: state_next.rdata = strapView;
				INDICATOR_STATE_OFS: state_next.rdata = indView;
				default: state_next.rdata = 32'h0000_0000;
			endcase
		end

		// selector writes in the access cycle, merged per byte lane;
		// bit 24 sits in byte 3 and bits 23:22 in byte 2, so a field
		// may be written in part; strap and indicator words are read only
		if (writeAccess) begin
			if (hitWan) begin
				state_next.wanSel0 = mergeField(state_reg.wanSel0,
					pwdata[WAN_SEL0_LSB +: SEL_WIDTH],
					wrMask[WAN_SEL0_LSB +: SEL_WIDTH]);
				state_next.wanSel1 = mergeField(state_reg.wanSel1,
					pwdata[WAN_SEL1_LSB +: SEL_WIDTH],
					wrMask[WAN_SEL1_LSB +: SEL_WIDTH]);
			end
			if (hitSw) begin
				state_next.lanSel0 = mergeField(state_reg.lanSel0,
					pwdata[LAN_SEL0_LSB +: SEL_WIDTH],
					wrMask[LAN_SEL0_LSB +: SEL_WIDTH]);
				state_next.lanSel1 = mergeField(state_reg.lanSel1,
					pwdata[LAN_SEL1_LSB +: SEL_WIDTH],
					wrMask[LAN_SEL1_LSB +: SEL_WIDTH]);
			end
		end
	end

	// ----------------------------------------
	// state registers
	// ----------------------------------------

	// single register bank with asynchronous reset
	// reset releases every shared pin at once, so the board straps win
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg.st <= ST_SAMPLE;
			state_reg.settle <= 2'h0;
			state_reg.widthSync1 <= 2'h0;
			state_reg.widthSync2 <= 2'h0;
			state_reg.rtsSync1 <= 1'b0;
			state_reg.rtsSync2 <= 1'b0;
			state_reg.bankWidth <= WIDTH_RESERVED;
			state_reg.cpuClkStrap <= 1'b0;
			state_reg.strapDec.bootBankWidthStrap <= WIDTH_RESERVED;
			state_reg.strapDec.width8 <= 1'b0;
			state_reg.strapDec.width16 <= 1'b0;
			state_reg.strapDec.width32 <= 1'b0;
			state_reg.strapDec.widthReserved <= 1'b1;
			state_reg.strapDec.cpuClockSourceStrap <= 1'b0;
			state_reg.wanSel0 <= WAN_SEL0_RESET;
			state_reg.wanSel1 <= WAN_SEL1_RESET;
			state_reg.lanSel0 <= LAN_SEL0_RESET;
			state_reg.lanSel1 <= LAN_SEL1_RESET;
			state_reg.wanLed0 <= 1'b0;
			state_reg.wanLed1 <= 1'b0;
			state_reg.lanLed0 <= 4'h0;
			state_reg.lanLed1 <= 4'h0;
			state_reg.rtsOut_n <= 1'b1;
			state_reg.rdata <= 32'h0000_0000;
			state_reg.slvErr <= 1'b0;
		end else begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------

	// apb answer, zero wait states
	// pslverr only in the access cycle of an unmapped word
	assign pready = 1'b1;
	assign prdata = state_reg.rdata;
	assign pslverr = psel & penable & state_reg.slvErr;

	// shared pins stay released until straps are held
	// enables come from the state register, never from the raw reset
	assign wanIndicator0Out = state_reg.wanLed0;
	assign wanIndicator1Out = state_reg.wanLed1;
	assign wanIndicator0Oe = (state_reg.st == ST_RUN);
	assign wanIndicator1Oe = (state_reg.st == ST_RUN);
	assign serialRequestToSendOut_n = state_reg.rtsOut_n;
	assign serialRequestToSendOe = (state_reg.st == ST_RUN);

	// lan indicators are dedicated outputs
	assign lanIndicator0 = state_reg.lanLed0;
	assign lanIndicator1 = state_reg.lanLed1;

	// strap results for the boot fetch logic, registered at latch
	assign strap = state_reg.strapDec;
	assign strapLatched = (state_reg.st == ST_RUN);

endmodule

// ---- test/plsb_led_strap_props.sv ----
// plsb_led_strap_props: port checks of indicator selection and strap capture.
// assumes a well formed apb master; bound to plsb_led_strap below.
`timescale 1ns/1ps
module plsb_led_strap_props
	import plsb_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// apb request
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic pready,
	// status and pins
	input wire plsb_port_stat_s wanStat,
	input wire plsb_port_stat_s [LAN_PORTS-1:0] lanStat,
	input wire logic serialTxRequest,
	input wire logic wanIndicator0In,
	input wire logic wanIndicator1In,
	input wire logic serialRequestToSendIn,
	input wire logic wanIndicator0Out,
	input wire logic wanIndicator1Out,
	input wire logic wanIndicator0Oe,
	input wire logic wanIndicator1Oe,
	input wire logic serialRequestToSendOut_n,
	input wire logic serialRequestToSendOe,
	input wire logic [LAN_PORTS-1:0] lanIndicator0,
	input wire logic [LAN_PORTS-1:0] lanIndicator1,
	// latched straps
	input wire plsb_strap_s strap,
	input wire logic strapLatched
);
	// shadow of the selectors: wan0, wan1, lan0, lan1, taken at the write edge
	logic [11:0] selReg;
	logic wrEdge;
	assign wrEdge = psel && penable && pready && pwrite;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			selReg <= {WAN_SEL0_RESET, WAN_SEL1_RESET, LAN_SEL0_RESET, LAN_SEL1_RESET};
		end else if (wrEdge && paddr == WAN_MISC_CTRL_OFS && pstrb[0]) begin
			selReg[11:6] <= {pwdata[2:0], pwdata[6:4]};
		end else if (wrEdge && paddr == SWITCH_CTRL0_OFS) begin
			selReg[5:2] <= pstrb[3] ? pwdata[27:24] : selReg[5:2];
			selReg[1:0] <= pstrb[2] ? pwdata[23:22] : selReg[1:0];
		end
	end

	// event chosen by a selector, per port
	function automatic logic [3:0] pick(input logic [2:0] s, input plsb_port_stat_s [3:0] p);
		for (int i = 0; i < 4; i++) begin
			case (s)
				SEL_SPEED: pick[i] = p[i].speed100;
				SEL_LINK: pick[i] = p[i].linkUp;
				SEL_DUPLEX: pick[i] = p[i].fullDuplex;
				SEL_COLLISION: pick[i] = p[i].collision;
				SEL_ACTIVITY: pick[i] = p[i].activity;
				SEL_FD_COLLISION: pick[i] = p[i].collision & p[i].fullDuplex;
				SEL_LINK_ACT: pick[i] = p[i].linkUp & ~p[i].activity;
				default: pick[i] = 1'b0;
			endcase
		end
	endfunction

	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking dc @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_run; strapLatched && $past(strapLatched); endsequence
	sequence s_latchRise; !strapLatched ##1 strapLatched; endsequence
	property p_wan0;
		s_run |-> {4{wanIndicator0Out}} == pick($past(selReg[11:9]), {4{$past(wanStat)}});
	endproperty
	a_wan0: assert property (p_wan0) else $error("wan indicator 0 wrong");
	property p_wan1;
		s_run |-> {4{wanIndicator1Out}} == pick($past(selReg[8:6]), {4{$past(wanStat)}});
	endproperty
	a_wan1: assert property (p_wan1) else $error("wan indicator 1 wrong");
	property p_lan0; s_run |-> lanIndicator0 == pick($past(selReg[5:3]), $past(lanStat)); endproperty
	a_lan0: assert property (p_lan0) else $error("lan indicator 0 wrong");
	property p_lan1; s_run |-> lanIndicator1 == pick($past(selReg[2:0]), $past(lanStat)); endproperty
	a_lan1: assert property (p_lan1) else $error("lan indicator 1 wrong");
	property p_oeFollow;
		{wanIndicator0Oe, wanIndicator1Oe, serialRequestToSendOe} == {3{strapLatched}};
	endproperty
	a_oeFollow: assert property (p_oeFollow) else $error("pin enable wrong");
	property p_capture;
		s_latchRise |-> strap.bootBankWidthStrap == $past({wanIndicator1In, wanIndicator0In})
			&& strap.cpuClockSourceStrap == $past(serialRequestToSendIn);
	endproperty
	a_capture: assert property (p_capture) else $error("strap capture wrong");
	property p_hold; strapLatched |=> strapLatched && $stable(strap); endproperty
	a_hold: assert property (p_hold) else $error("strap not held");
	property p_decode;
		strapLatched |-> strap.width8 == (strap.bootBankWidthStrap == WIDTH_8BIT)
			&& strap.width16 == (strap.bootBankWidthStrap == WIDTH_16BIT)
			&& strap.width32 == (strap.bootBankWidthStrap == WIDTH_32BIT)
			&& strap.widthReserved == (strap.bootBankWidthStrap == WIDTH_RESERVED);
	endproperty
	a_decode: assert property (p_decode) else $error("width decode wrong");
	property p_rts; serialRequestToSendOe |-> serialRequestToSendOut_n == !$past(serialTxRequest);
	endproperty
	a_rts: assert property (p_rts) else $error("request to send wrong");
endmodule

bind plsb_led_strap plsb_led_strap_props u_props (.*);

// ---- test/plsb_phy_model.sv ----
// plsb_phy_model: stand-in for the port phy and mac status outputs.
// assumes the bench hands a random word on clk, fresh each cycle only while it samples.
`timescale 1ns/1ps
module plsb_phy_model
	import plsb_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// random word from the bench
	input wire logic [31:0] rndWord,
	// status toward the indicator logic
	output plsb_port_stat_s wanStat,
	output plsb_port_stat_s [LAN_PORTS-1:0] lanStat
);
	// status moves only on the clock, link down in reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wanStat <= '0;
			lanStat <= '0;
		end else begin
			wanStat <= rndWord[4:0];
			lanStat <= rndWord[24:5];
		end
	end
endmodule

// ---- test/testbench.sv ----
// testbench: random status and apb traffic against plsb_led_strap.
// assumes the checker is bound in and the phy model drives status.
`timescale 1ns/1ps
module testbench
	import plsb_pkg::*;
;
	logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, rndWord = 32'h0000_0000, rnd = 32'h0001_72F2;
	logic [3:0] pstrb = 4'h0;
	logic serialTxRequest = 1'b0, strapCpu = 1'b0;
	logic [1:0] strapWidth = 2'h1;
	logic [31:0] prdata;
	logic pready, pslverr, wanIndicator0Out, wanIndicator0Oe, wanIndicator1Out, wanIndicator1Oe;
	logic serialRequestToSendOut_n, serialRequestToSendOe, strapLatched;
	logic wanIndicator0In, wanIndicator1In, serialRequestToSendIn;
	logic [3:0] lanIndicator0, lanIndicator1;
	logic [2:0] ws0, ws1, ls0, ls1;
	plsb_strap_s strap;
	plsb_port_stat_s wanStat;
	plsb_port_stat_s [3:0] lanStat;
	int failures = 0, cmpCount = 0;

	always #(CLK_PERIOD_NS / 2) clk = ~clk;
	// board straps hold the shared pins while the device does not drive
	assign wanIndicator0In = wanIndicator0Oe ? wanIndicator0Out : strapWidth[0];
	assign wanIndicator1In = wanIndicator1Oe ? wanIndicator1Out : strapWidth[1];
	assign serialRequestToSendIn = serialRequestToSendOe ? serialRequestToSendOut_n : strapCpu;
	plsb_led_strap dut (.*);
	plsb_phy_model u_phy (.clk(clk), .rst_n(rst_n), .rndWord(rndWord), .wanStat(wanStat),
		.lanStat(lanStat));

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	// expected indicator for one port
	function automatic logic ind(input logic [2:0] s, input plsb_port_stat_s p);
		case (s)
			SEL_SPEED: return p.speed100;
			SEL_LINK: return p.linkUp;
			SEL_DUPLEX: return p.fullDuplex;
			SEL_COLLISION: return p.collision;
			SEL_ACTIVITY: return p.activity;
			SEL_FD_COLLISION: return p.collision & p.fullDuplex;
			SEL_LINK_ACT: return p.linkUp & ~p.activity;
			default: return 1'b0;
		endcase
	endfunction

	task automatic test_done();
		$display("counts: compares %0d mismatches %0d", cmpCount, failures);
		if (failures == 0 && cmpCount > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic bail();
		failures++;
		$display("mismatch wait expected done seen timeout");
		test_done();
	endtask
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		cmpCount++;
		if (g !== x) begin
			failures++;
			$display("mismatch %s expected %h seen %h", n, x, g);
		end
	endtask
	// one apb transfer, waiting on pready under a bound
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [31:0] r, output logic e);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) bail();
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic readChk(input logic [11:0] a, input logic [31:0] x);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0000_0000, 4'h0, r, e);
		chk("rdata", x, r);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, s, r, e);
		chk("pslverr", 32'h0000_0000, {31'h0, e});
	endtask
	task automatic setSel(input logic [2:0] a, b, l0, l1);
		rnd = lfsr(rnd);
		wr(WAN_MISC_CTRL_OFS, {rnd[24:0], b, rnd[25], a}, 4'hF);
		wr(SWITCH_CTRL0_OFS, {rnd[3:0], l0, l1, rnd[21:0]}, 4'hF);
		{ws0, ws1, ls0, ls1} = {a, b, l0, l1};
		readChk(WAN_MISC_CTRL_OFS, {25'h0, b, 1'b0, a});
		readChk(SWITCH_CTRL0_OFS, {4'h0, l0, l1, 22'h0});
	endtask
	// reset with given straps, then check what was latched
	task automatic doReset(input logic [1:0] w, input logic c);
		int n;
		@(posedge clk);
		rst_n <= 1'b0;
		strapWidth <= w;
		strapCpu <= c;
		{ws0, ws1, ls0, ls1} = {WAN_SEL0_RESET, WAN_SEL1_RESET, LAN_SEL0_RESET, LAN_SEL1_RESET};
		repeat (RESET_MIN_CYCLES) @(posedge clk);
		chk("pin enables", 32'h0000_0000,
			{29'h0, wanIndicator0Oe, wanIndicator1Oe, serialRequestToSendOe});
		rst_n <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (strapLatched !== 1'b1 && n < 20);
		if (n >= 20) bail();
		#1;
		chk("strap", {25'h0, w, w == 2'h1, w == 2'h2, w == 2'h3, w == 2'h0, c}, {25'h0, strap});
		chk("pin enables", 32'h0000_0007,
			{29'h0, wanIndicator0Oe, wanIndicator1Oe, serialRequestToSendOe});
		readChk(STRAP_STATUS_OFS, {27'h0, 1'b1, w == 2'h0, c, w});
	endtask
	// random status each cycle, outputs compared one edge later
	task automatic sample(input int n);
		plsb_port_stat_s ws;
		plsb_port_stat_s [3:0] ls;
		logic tx;
		logic [3:0] e0, e1;
		repeat (n) begin
			@(posedge clk);
			ws = wanStat;
			ls = lanStat;
			tx = serialTxRequest;
			rnd = lfsr(rnd);
			rndWord <= rnd;
			serialTxRequest <= rnd[31];
			#1;
			for (int i = 0; i < 4; i++) begin
				e0[i] = ind(ls0, ls[i]);
				e1[i] = ind(ls1, ls[i]);
			end
			chk("indicators", {21'h0, ind(ws0, ws), ind(ws1, ws), e0, e1, ~tx},
				{21'h0, wanIndicator0Out, wanIndicator1Out, lanIndicator0, lanIndicator1,
				serialRequestToSendOut_n});
		end
	endtask

	initial begin
		logic [31:0] r;
		logic e;
		logic [2:0] cd;
		logic [9:0] q;
		for (int k = 0; k < 3; k++) begin
			doReset(2'(k + 1), k[0]);
			readChk(WAN_MISC_CTRL_OFS, 32'h0000_0041);
			readChk(SWITCH_CTRL0_OFS, 32'h0300_0000);
			for (int c = 0; c < 8; c++) begin
				cd = 3'(c);
				setSel(cd, ~cd, ~cd, cd);
				sample(12);
			end
			wr(SWITCH_CTRL0_OFS, 32'hFF40_0000, 4'h4);
			ls1 = 3'h5;
			readChk(SWITCH_CTRL0_OFS, 32'h0140_0000);
			sample(12);
			wr(STRAP_STATUS_OFS, 32'hFFFF_FFFF, 4'hF);
			readChk(STRAP_STATUS_OFS, {27'h0, 1'b1, 1'b0, k[0], 2'(k + 1)});
			// status has stood still since the last sample, so the view is steady
			for (int i = 0; i < 4; i++) begin
				q[i + 2] = ind(ls0, lanStat[i]);
				q[i + 6] = ind(ls1, lanStat[i]);
			end
			q[1:0] = {ind(ws1, wanStat), ind(ws0, wanStat)};
			readChk(INDICATOR_STATE_OFS, {22'h0, q});
			apb(1'b0, 12'h010, 32'h0000_0000, 4'h0, r, e);
			chk("pslverr", 32'h0000_0001, {31'h0, e});
			chk("rdata", 32'h0000_0000, r);
			$display("test reset %0d done", k);
		end
		test_done();
	end
endmodule
